// file: hw/pcm_pkg.sv
package pcm_pkg;

    // byte offsets of the configuration doublewords
    localparam logic [11:0] OFS_IDS = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_CLASS = 12'h008;
    localparam logic [11:0] OFS_MISC = 12'h00c;
    localparam logic [11:0] OFS_BAR0 = 12'h010;
    localparam logic [11:0] OFS_BAR1 = 12'h014;
    localparam logic [11:0] OFS_BAR2 = 12'h018;
    localparam logic [11:0] OFS_BAR3 = 12'h01c;
    localparam logic [11:0] OFS_BAR4 = 12'h020;
    localparam logic [11:0] OFS_BAR5 = 12'h024;
    localparam logic [11:0] OFS_CARDBUS = 12'h028;
    localparam logic [11:0] OFS_SUBSYS = 12'h02c;
    localparam logic [11:0] OFS_ROM_EP = 12'h030;
    localparam logic [11:0] OFS_CAPABILITY_LIST_POINTER = 12'h034;
    localparam logic [11:0] OFS_ROM_RP = 12'h038;
    localparam logic [11:0] OFS_INTR = 12'h03c;
    localparam logic [11:0] OFS_ROOT_CTRL = 12'h07c;
    localparam logic [11:0] OFS_LINK_CTRL2 = 12'h090;
    localparam logic [11:0] OFS_GAP_FIRST = 12'h094;
    localparam logic [11:0] OFS_MSIX_HDR = 12'h09c;
    localparam logic [11:0] OFS_MSIX_TABLE = 12'h0a0;
    localparam logic [11:0] OFS_MSIX_PBA = 12'h0a4;
    localparam logic [11:0] OFS_LEGACY_FIRST = 12'h0a8;
    localparam logic [11:0] OFS_LEGACY_LAST = 12'h0ff;
    localparam logic [11:0] OFS_SN_HDR = 12'h100;
    localparam logic [11:0] OFS_SN_LOW = 12'h104;
    localparam logic [11:0] OFS_SN_HIGH = 12'h108;
    localparam logic [11:0] OFS_VC_HDR = 12'h10c;
    localparam logic [11:0] OFS_VC_CAP1 = 12'h110;
    localparam logic [11:0] OFS_VC_CAP2 = 12'h114;
    localparam logic [11:0] OFS_VC_PORT_CTRL = 12'h118;
    localparam logic [11:0] OFS_VC_RES_CAP = 12'h11c;
    localparam logic [11:0] OFS_VC_RES_CTRL = 12'h120;
    localparam logic [11:0] OFS_VC_RES_STAT = 12'h124;
    localparam logic [11:0] OFS_VS_HDR = 12'h128;
    localparam logic [11:0] OFS_VS_VENDOR = 12'h12c;
    localparam logic [11:0] OFS_LB_CMD = 12'h130;
    localparam logic [11:0] OFS_LB_STAT = 12'h134;
    localparam logic [11:0] OFS_LB_ERR1 = 12'h138;
    localparam logic [11:0] OFS_LB_ERR2 = 12'h13c;
    localparam logic [11:0] OFS_EXT_RSVD_FIRST = 12'h140;

    // storage slots for the writable doublewords
    localparam int NUM_SLOTS = 23;
    localparam logic [4:0] SLOT_CMD = 5'h00;
    localparam logic [4:0] SLOT_MISC = 5'h01;
    localparam logic [4:0] SLOT_BAR0 = 5'h02;
    localparam logic [4:0] SLOT_ROM = 5'h08;
    localparam logic [4:0] SLOT_INTR = 5'h09;
    localparam logic [4:0] SLOT_BR_BUS = 5'h0a;
    localparam logic [4:0] SLOT_ROOT_CTRL = 5'h16;
    localparam logic [4:0] SLOT_LINK_CTRL2 = 5'h11;
    localparam logic [4:0] SLOT_MSIX = 5'h12;
    localparam logic [4:0] SLOT_VC_PORT = 5'h13;
    localparam logic [4:0] SLOT_VC_RES = 5'h14;
    localparam logic [4:0] SLOT_LB_CMD = 5'h15;
    localparam logic [4:0] SLOT_NONE = 5'h1f;

    // writable bit masks and fixed read values
    localparam logic [31:0] WM_CMD = 32'h0000_0547;
    localparam logic [31:0] RO_STATUS_CAPLIST = 32'h0010_0000;
    localparam logic [31:0] WM_MISC = 32'h0000_ffff;
    localparam logic [31:0] WM_INTR_EP = 32'h0000_00ff;
    localparam logic [31:0] WM_INTR_RP = 32'h0fff_00ff;
    localparam logic [31:0] RO_INTR_PIN_A = 32'h0000_0100;
    localparam logic [31:0] WM_IO_WIN = 32'h0000_f0f0;
    localparam logic [31:0] RO_IO_32BIT = 32'h0000_0101;
    localparam logic [31:0] WM_MEM_WIN = 32'hfff0_fff0;
    localparam logic [31:0] RO_PREF_64BIT = 32'h0001_0001;
    localparam logic [31:0] WM_ALL = 32'hffff_ffff;
    localparam logic [31:0] WM_ROOT_CTRL = 32'h0000_001f;
    localparam logic [31:0] WM_LOW_HALF = 32'h0000_ffff;
    localparam logic [31:0] WM_MSIX = 32'hc000_0000;
    localparam logic [31:0] WM_VC_PORT = 32'h0000_000e;
    localparam logic [31:0] WM_VC_RES = 32'h0000_00fe;
    localparam logic [31:0] RO_VC_RES_CTRL = 32'h8000_0001;
    localparam logic [31:0] WM_LB_CMD = 32'h0000_0001;
    localparam logic [31:0] RO_CAPABILITY_LIST_POINTER = 32'h0000_0040;
    localparam logic [7:0] HDR_TYPE_EP = 8'h00;
    localparam logic [7:0] HDR_TYPE_RP = 8'h01;
    localparam logic [15:0] CAPID_MSIX = 16'h0011;
    localparam logic [15:0] CAPID_SN = 16'h0003;
    localparam logic [15:0] CAPID_VC = 16'h0002;
    localparam logic [15:0] CAPID_VS = 16'h000b;
    localparam logic [3:0] CAP_VERSION = 4'h1;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int MAX_LANES = 8;

    // one decoded configuration address
    typedef struct packed {
        logic hit;
        logic [4:0] slot;
        logic [31:0] wmask;
        logic [31:0] rov;
    } pcm_dec_t;

endpackage

// file: hw/pcm_config_space.sv
`timescale 1ns/1ns

// Behaviour
// - the two doublewords after the second link control register read as zero.
// - legacy range 0A8h to 0FFh is reserved and reads zero.
// - extended reads from 140h to FFFh still complete successfully with zero.
// - endpoint builds read root-port-only slot and root registers as zero.
// - serial-number capability header at 100h, serial halves at 104h and 108h.
// - virtual-channel capability at 10Ch, its registers following through 124h.
// - vendor capability at 128h, vendor header 12Ch, loopback command/status 130h/134h.
// - two loopback error count registers sit at 138h and 13Ch.
// - endpoint Type 0 header: six BARs, cardbus, subsystem, ROM 30h, pointer 34h.
// - root-port Type 1 header: two BARs, bus numbers 18h, ROM 38h, bridge 3Ch.
// - root-port upper prefetch base 28h, limit 2Ch, upper I/O halves 30h.
// - system reset is asynchronous active low and resets the whole core.
// - one, two, four or eight lane builds use lanes from zero upward.
// - each lane has a transmit pair and a receive pair, each two legs.
module pcm_config_space #(
    parameter bit IS_ROOT_PORT = 1'b0,
    parameter int LANES = 1,
    parameter bit MSIX_EN = 1'b1,
    parameter bit SN_EN = 1'b1,
    parameter bit VC_EN = 1'b1,
    parameter bit VS_EN = 1'b1,
    parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
    parameter logic [15:0] FUNCTION_IDENTIFIERS = 16'h0001, // arbitrary value
    parameter logic [31:0] CLASS_REV = 32'h0000_0000,
    parameter logic [31:0] SUBSYS_IDS = 32'h0001_1234, // arbitrary value
    parameter logic [31:0] BAR_SIZE_MASK = 32'hfff0_0000,
    parameter logic [31:0] ROM_SIZE_MASK = 32'hfff0_0001,
    parameter logic [63:0] SERIAL_NUMBER = 64'h0000_0000_0000_0001, // arbitrary value
    parameter logic [31:0] VENDOR_HEADER = 32'h0000_0000,
    parameter logic [10:0] MSIX_TABLE_SIZE = 11'h000,
    parameter logic [31:0] MSIX_TABLE_LOC = 32'h0000_0000,
    parameter logic [31:0] MSIX_PBA_LOC = 32'h0000_0800
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_sys_reset_n,
    input wire logic i_cfg_valid,
    input wire logic i_cfg_write,
    input wire logic [11:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    output logic o_cfg_ready,
    output logic o_cpl_valid,
    output logic o_cpl_write,
    output logic [31:0] o_cpl_data,
    input wire logic [7:0] i_rx_p,
    input wire logic [7:0] i_rx_n,
    output logic [7:0] o_tx_p,
    output logic [7:0] o_tx_n,
    output logic [7:0] o_lane_used
);

    // the whole state of the block
    typedef struct packed {
        logic [pcm_pkg::NUM_SLOTS-1:0][31:0] regs;
        logic cpl_valid;
        logic cpl_write;
        logic [31:0] cpl_data;
        logic [7:0] tx_p;
        logic [7:0] tx_n;
        logic lb_active;
        logic [31:0] err1;
        logic [31:0] err2;
    } pcm_state_t;

    pcm_state_t state_q;
    pcm_state_t state_d;
    logic core_reset;
    logic [7:0] lane_mask;
    logic [31:0] lb_status;
    pcm_pkg::pcm_dec_t dec;

    // combined reset, active high
    // either reset source clears everything at once, no clock needed
    assign core_reset = i_reset | ~i_sys_reset_n;

    assign lane_mask = 8'((16'h0001 << LANES) - 16'h0001);
    assign o_lane_used = lane_mask;
    assign o_cfg_ready = 1'b1; // every request is answered in one cycle

    // loopback status: active, error seen, lanes in use
    assign lb_status = {16'h0000, lane_mask, 6'h00, (state_q.err1 != 32'h0) | (state_q.err2 != 32'h0),
                        state_q.lb_active};

    // next pointer of an extended capability, zero ends the chain
    function automatic logic [11:0] next_ext(input bit vc, input bit vs);
        next_ext = vc ? pcm_pkg::OFS_VC_HDR : (vs ? pcm_pkg::OFS_VS_HDR : 12'h000);
    endfunction

    // extended capability header word
    function automatic logic [31:0] ext_hdr(input logic [15:0] id, input logic [11:0] nxt);
        ext_hdr = {nxt, pcm_pkg::CAP_VERSION, id};
    endfunction

    // map one doubleword address to its storage slot, writable mask and fixed bits
    function automatic pcm_pkg::pcm_dec_t decode(input logic [11:0] a);
        pcm_pkg::pcm_dec_t d;
        d = '0;
        d.slot = pcm_pkg::SLOT_NONE;
        case (a)
            pcm_pkg::OFS_IDS: begin
                d.hit = 1'b1;
                d.rov = {FUNCTION_IDENTIFIERS, VENDOR_ID};
            end
            pcm_pkg::OFS_CMD: begin
                d = '{1'b1, pcm_pkg::SLOT_CMD, pcm_pkg::WM_CMD, pcm_pkg::RO_STATUS_CAPLIST};
            end
            pcm_pkg::OFS_CLASS: begin
                d.hit = 1'b1;
                d.rov = CLASS_REV;
            end
            pcm_pkg::OFS_MISC: begin
                d = '{1'b1, pcm_pkg::SLOT_MISC, pcm_pkg::WM_MISC, 32'h0000_0000};
                d.rov[23:16] = IS_ROOT_PORT ? pcm_pkg::HDR_TYPE_RP : pcm_pkg::HDR_TYPE_EP;
            end
            pcm_pkg::OFS_BAR0, pcm_pkg::OFS_BAR1: begin
                // word index minus four picks the window slot, so windows never share storage
                d = '{1'b1, 5'(pcm_pkg::SLOT_BAR0 + {1'b0, a[5:2]} - 5'h04), BAR_SIZE_MASK, 32'h0000_0000};
            end
            pcm_pkg::OFS_BAR2, pcm_pkg::OFS_BAR3, pcm_pkg::OFS_BAR4, pcm_pkg::OFS_BAR5: begin
                if (IS_ROOT_PORT) begin
                    d.hit = 1'b1;
                    d.slot = 5'(pcm_pkg::SLOT_BR_BUS + {1'b0, a[5:2]} - 5'h06);
                    case (a)
                        pcm_pkg::OFS_BAR2: d.wmask = pcm_pkg::WM_ALL;
                        pcm_pkg::OFS_BAR3: begin
                            d.wmask = pcm_pkg::WM_IO_WIN;
                            d.rov = pcm_pkg::RO_IO_32BIT;
                        end
                        pcm_pkg::OFS_BAR4: d.wmask = pcm_pkg::WM_MEM_WIN;
                        default: begin
                            d.wmask = pcm_pkg::WM_MEM_WIN;
                            d.rov = pcm_pkg::RO_PREF_64BIT;
                        end
                    endcase
                end else begin
                    d = '{1'b1, 5'(pcm_pkg::SLOT_BAR0 + {1'b0, a[5:2]} - 5'h04), BAR_SIZE_MASK, 32'h0000_0000};
                end
            end
            pcm_pkg::OFS_CARDBUS, pcm_pkg::OFS_SUBSYS: begin
                if (IS_ROOT_PORT) begin
                    d = '{1'b1, 5'(pcm_pkg::SLOT_BR_BUS + {1'b0, a[5:2]} - 5'h06), pcm_pkg::WM_ALL, 32'h0000_0000};
                end else begin
                    d.hit = 1'b1;
                    d.rov = (a == pcm_pkg::OFS_SUBSYS) ? SUBSYS_IDS : 32'h0000_0000;
                end
            end
            pcm_pkg::OFS_ROM_EP: begin
                if (IS_ROOT_PORT) begin
                    d = '{1'b1, 5'(pcm_pkg::SLOT_BR_BUS + 5'h06), pcm_pkg::WM_ALL, 32'h0000_0000};
                end else begin
                    d = '{1'b1, pcm_pkg::SLOT_ROM, ROM_SIZE_MASK, 32'h0000_0000};
                end
            end
            pcm_pkg::OFS_CAPABILITY_LIST_POINTER: begin
                d.hit = 1'b1;
                d.rov = pcm_pkg::RO_CAPABILITY_LIST_POINTER;
            end
            pcm_pkg::OFS_ROM_RP: begin
                if (IS_ROOT_PORT) begin
                    d = '{1'b1, pcm_pkg::SLOT_ROM, ROM_SIZE_MASK, 32'h0000_0000};
                end
            end
            pcm_pkg::OFS_INTR: begin
                d = '{1'b1, pcm_pkg::SLOT_INTR, IS_ROOT_PORT ? pcm_pkg::WM_INTR_RP : pcm_pkg::WM_INTR_EP,
                      pcm_pkg::RO_INTR_PIN_A};
            end
            // root control only on root ports
            pcm_pkg::OFS_ROOT_CTRL: begin
                if (IS_ROOT_PORT) begin
                    d = '{1'b1, pcm_pkg::SLOT_ROOT_CTRL, pcm_pkg::WM_ROOT_CTRL, 32'h0000_0000};
                end
            end
            pcm_pkg::OFS_LINK_CTRL2: begin
                d = '{1'b1, pcm_pkg::SLOT_LINK_CTRL2, pcm_pkg::WM_LOW_HALF, 32'h0000_0000};
            end
            pcm_pkg::OFS_MSIX_HDR: begin
                if (MSIX_EN) begin
                    d = '{1'b1, pcm_pkg::SLOT_MSIX, pcm_pkg::WM_MSIX,
                          {5'h00, MSIX_TABLE_SIZE, pcm_pkg::CAPID_MSIX}};
                end
            end
            pcm_pkg::OFS_MSIX_TABLE, pcm_pkg::OFS_MSIX_PBA: begin
                d.hit = MSIX_EN;
                d.rov = (a == pcm_pkg::OFS_MSIX_PBA) ? MSIX_PBA_LOC : MSIX_TABLE_LOC;
            end
            pcm_pkg::OFS_SN_HDR: begin
                d.hit = SN_EN;
                d.rov = ext_hdr(pcm_pkg::CAPID_SN, next_ext(VC_EN, VS_EN));
            end
            pcm_pkg::OFS_SN_LOW: begin
                d.hit = SN_EN;
                d.rov = SERIAL_NUMBER[31:0];
            end
            pcm_pkg::OFS_SN_HIGH: begin
                d.hit = SN_EN;
                d.rov = SERIAL_NUMBER[63:32];
            end
            pcm_pkg::OFS_VC_HDR: begin
                d.hit = VC_EN;
                d.rov = ext_hdr(pcm_pkg::CAPID_VC, next_ext(1'b0, VS_EN));
            end
            pcm_pkg::OFS_VC_CAP1, pcm_pkg::OFS_VC_CAP2, pcm_pkg::OFS_VC_RES_CAP, pcm_pkg::OFS_VC_RES_STAT: begin
                d.hit = VC_EN; // only VC0, no arbitration tables
            end
            pcm_pkg::OFS_VC_PORT_CTRL: begin
                if (VC_EN) begin
                    d = '{1'b1, pcm_pkg::SLOT_VC_PORT, pcm_pkg::WM_VC_PORT, 32'h0000_0000};
                end
            end
            pcm_pkg::OFS_VC_RES_CTRL: begin
                if (VC_EN) begin
                    d = '{1'b1, pcm_pkg::SLOT_VC_RES, pcm_pkg::WM_VC_RES, pcm_pkg::RO_VC_RES_CTRL};
                end
            end
            pcm_pkg::OFS_VS_HDR: begin
                d.hit = VS_EN;
                d.rov = ext_hdr(pcm_pkg::CAPID_VS, 12'h000);
            end
            pcm_pkg::OFS_VS_VENDOR: begin
                d.hit = VS_EN;
                d.rov = VENDOR_HEADER;
            end
            pcm_pkg::OFS_LB_CMD: begin
                if (VS_EN) begin
                    d = '{1'b1, pcm_pkg::SLOT_LB_CMD, pcm_pkg::WM_LB_CMD, 32'h0000_0000};
                end
            end
            pcm_pkg::OFS_LB_STAT: begin
                d.hit = VS_EN;
                d.rov = lb_status;
            end
            pcm_pkg::OFS_LB_ERR1: begin
                d.hit = VS_EN;
                d.rov = state_q.err1;
            end
            pcm_pkg::OFS_LB_ERR2: begin
                d.hit = VS_EN;
                d.rov = state_q.err2;
            end
            default: d = '{1'b0, pcm_pkg::SLOT_NONE, 32'h0000_0000, 32'h0000_0000};
        endcase
        decode = d;
    endfunction

    assign dec = decode({i_cfg_addr[11:2], 2'b00});

    // next state: configuration access, completion, loopback lanes
    always_comb begin
        logic [31:0] be_mask;
        logic [31:0] old;
        logic lb_en;
        logic [7:0] bad_pair;
        logic [7:0] mismatch;
        be_mask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
        old = 32'h0000_0000;
        state_d = state_q;
        state_d.cpl_valid = 1'b0;
        state_d.cpl_write = 1'b0;
        if (i_cfg_valid) begin
            state_d.cpl_valid = 1'b1;
            state_d.cpl_write = i_cfg_write;
            state_d.cpl_data = 32'h0000_0000;
            if (dec.slot != pcm_pkg::SLOT_NONE) begin
                old = state_q.regs[dec.slot];
            end
            if (!i_cfg_write) begin
                state_d.cpl_data = dec.hit ? ((old & dec.wmask) | dec.rov) : 32'h0000_0000;
            end else if (dec.slot != pcm_pkg::SLOT_NONE) begin
                // only writable bits take the write
                state_d.regs[dec.slot] = (old & ~(dec.wmask & be_mask)) | (i_cfg_wdata & dec.wmask & be_mask);
            end
        end
        // loopback steered by the command bit
        lb_en = VS_EN && state_q.regs[pcm_pkg::SLOT_LB_CMD][0];
        state_d.lb_active = lb_en;
        bad_pair = (i_rx_p ~^ i_rx_n) & lane_mask;
        mismatch = (i_rx_p ^ state_q.tx_p) & lane_mask;
        // counts restart when loopback starts, saturate at the top
        if (lb_en && !state_q.lb_active) begin
            state_d.err1 = 32'h0000_0000;
            state_d.err2 = 32'h0000_0000;
        end else if (lb_en) begin
            if ((bad_pair != 8'h00) && (state_q.err1 != 32'hffff_ffff)) begin
                state_d.err1 = state_q.err1 + 32'h0000_0001;
            end
            if (state_q.lb_active && (mismatch != 8'h00) && (state_q.err2 != 32'hffff_ffff)) begin
                state_d.err2 = state_q.err2 + 32'h0000_0001;
            end
        end
        // differential pairs on used lanes only
        state_d.tx_p = lb_en ? (i_rx_p & lane_mask) : 8'h00;
        state_d.tx_n = lane_mask & ~state_d.tx_p;
    end

    // single state register
    always_ff @(posedge i_clock or posedge core_reset) begin
        if (core_reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_cpl_valid = state_q.cpl_valid;
    assign o_cpl_write = state_q.cpl_write;
    assign o_cpl_data = state_q.cpl_data;
    assign o_tx_p = state_q.tx_p;
    assign o_tx_n = state_q.tx_n;

endmodule

// file: tb/pcm_config_space_sva.sv
`timescale 1ns/1ns

// watches completions and lanes at the ports of the configuration space block
module pcm_config_space_sva #(
    parameter bit IS_ROOT_PORT = 1'b0,
    parameter int LANES = 1
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_sys_reset_n,
    input wire logic i_cfg_valid,
    input wire logic i_cfg_write,
    input wire logic [11:0] i_cfg_addr,
    input wire logic o_cpl_valid,
    input wire logic o_cpl_write,
    input wire logic [31:0] o_cpl_data,
    input wire logic [7:0] o_tx_p,
    input wire logic [7:0] o_lane_used
);
    logic rd;
    logic [9:0] wa;

    // read strobe and word address, shared by the map checks
    assign rd = i_cfg_valid && !i_cfg_write;
    assign wa = i_cfg_addr[11:2];

    property p_cpl;
        @(posedge i_clock) disable iff (i_reset || !i_sys_reset_n)
        i_cfg_valid |=> o_cpl_valid && (o_cpl_write == $past(i_cfg_write));
    endproperty
    a_cpl: assert property (p_cpl) else $error("request without matching completion");
    property p_quiet;
        @(posedge i_clock) disable iff (i_reset || !i_sys_reset_n)
        !i_cfg_valid |=> !o_cpl_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("completion without request");
    property p_gap;
        @(posedge i_clock) disable iff (i_reset || !i_sys_reset_n)
        rd && (wa inside {10'h025, 10'h026}) |=> o_cpl_data == 32'h0000_0000;
    endproperty
    a_gap: assert property (p_gap) else $error("gap after link control not zero");
    property p_legacy;
        @(posedge i_clock) disable iff (i_reset || !i_sys_reset_n)
        rd && (wa inside {[10'h02a:10'h03f]}) |=> o_cpl_data == 32'h0000_0000;
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy reserved range not zero");
    property p_ext;
        @(posedge i_clock) disable iff (i_reset || !i_sys_reset_n)
        rd && (wa >= 10'h050) |=> o_cpl_valid ##0 o_cpl_data == 32'h0000_0000;
    endproperty
    a_ext: assert property (p_ext) else $error("extended reserved read wrong");
    property p_root;
        @(posedge i_clock) disable iff (i_reset || !i_sys_reset_n)
        rd && !IS_ROOT_PORT && (wa inside {[10'h01d:10'h020]}) |=> o_cpl_data == 32'h0000_0000;
    endproperty
    a_root: assert property (p_root) else $error("root-only register visible on endpoint");
    property p_rsv38;
        @(posedge i_clock) disable iff (i_reset || !i_sys_reset_n)
        rd && !IS_ROOT_PORT && (wa == 10'h00e) |=> o_cpl_data == 32'h0000_0000;
    endproperty
    a_rsv38: assert property (p_rsv38) else $error("reserved header word not zero");
    property p_sn;
        @(posedge i_clock) disable iff (i_reset || !i_sys_reset_n)
        rd && (wa == 10'h040) |=> o_cpl_data[19:0] == 20'h10003;
    endproperty
    a_sn: assert property (p_sn) else $error("serial number header wrong");
    property p_vs;
        @(posedge i_clock) disable iff (i_reset || !i_sys_reset_n)
        rd && (wa == 10'h04a) |=> o_cpl_data[19:0] == 20'h1000b;
    endproperty
    a_vs: assert property (p_vs) else $error("vendor capability header wrong");
    property p_lane;
        @(posedge i_clock) disable iff (i_reset)
        o_lane_used == 8'((9'h001 << LANES) - 9'h001);
    endproperty
    a_lane: assert property (p_lane) else $error("lane mask wrong");
    property p_rst;
        @(posedge i_clock) disable iff (i_reset)
        !i_sys_reset_n |-> !o_cpl_valid && (o_tx_p == 8'h00);
    endproperty
    a_rst: assert property (p_rst) else $error("system reset did not clear core");
endmodule

bind pcm_config_space pcm_config_space_sva #(.IS_ROOT_PORT(IS_ROOT_PORT), .LANES(LANES)) pcm_config_space_sva_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_sys_reset_n(i_sys_reset_n), .i_cfg_valid(i_cfg_valid),
    .i_cfg_write(i_cfg_write), .i_cfg_addr(i_cfg_addr), .o_cpl_valid(o_cpl_valid), .o_cpl_write(o_cpl_write),
    .o_cpl_data(o_cpl_data), .o_tx_p(o_tx_p), .o_lane_used(o_lane_used)
);

// file: tb/pcm_lane_partner.sv
`timescale 1ns/1ns

// far end of the serial lanes: a pattern that moves every cycle, so a stuck loopback shows
module pcm_lane_partner (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_inject,
    output logic [7:0] o_rx_p,
    output logic [7:0] o_rx_n
);
    logic [7:0] pat_q;

    // pattern counter
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            pat_q <= 8'h5a;
        end else begin
            pat_q <= pat_q + 8'h01;
        end
    end
    assign o_rx_p = pat_q;
    assign o_rx_n = i_inject ? pat_q : ~pat_q; // inject makes both legs equal, a line fault
endmodule

// file: tb/tb_pcm_config_space.sv
`timescale 1ns/1ns

module tb_pcm_config_space;
    logic i_clock, i_reset, i_sys_reset_n, i_cfg_valid, i_cfg_write, inject, v;
    logic [11:0] i_cfg_addr;
    logic [3:0] i_cfg_be;
    logic [31:0] i_cfg_wdata, o_cpl_data;
    logic o_cfg_ready, o_cpl_valid, o_cpl_write;
    logic [7:0] rx_p, rx_n, o_tx_p, o_tx_n, o_lane_used;
    int fails, total_checks;
    // address and expected read value after reset, endpoint build
    logic [43:0] map [19] = '{44'h000_00011234, 44'h02c_00011234, 44'h034_00000040, 44'h038_00000000,
        44'h00c_00000000, 44'h07c_00000000, 44'h094_00000000, 44'h098_00000000, 44'h0a8_00000000,
        44'h0fc_00000000, 44'h100_10c10003, 44'h104_00000001, 44'h108_00000000, 44'h10c_12810002,
        44'h128_0001000b, 44'h138_00000000, 44'h13c_00000000, 44'h140_00000000, 44'hffc_00000000};

    pcm_config_space pcm_config_space_i (.i_clock(i_clock), .i_reset(i_reset), .i_sys_reset_n(i_sys_reset_n),
        .i_cfg_valid(i_cfg_valid), .i_cfg_write(i_cfg_write), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
        .i_cfg_wdata(i_cfg_wdata), .o_cfg_ready(o_cfg_ready), .o_cpl_valid(o_cpl_valid),
        .o_cpl_write(o_cpl_write), .o_cpl_data(o_cpl_data), .i_rx_p(rx_p), .i_rx_n(rx_n), .o_tx_p(o_tx_p),
        .o_tx_n(o_tx_n), .o_lane_used(o_lane_used));
    pcm_lane_partner pcm_lane_partner_i (.i_clock(i_clock), .i_reset(i_reset), .i_inject(inject),
        .o_rx_p(rx_p), .o_rx_n(rx_n));

    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one request, answer taken one edge later as the handshake fixes it
    task acc(input logic w, input logic [11:0] a, input logic [3:0] be, input logic [31:0] wd,
             input logic [31:0] exp);
        @(posedge i_clock);
        i_cfg_valid <= 1'b1;
        i_cfg_write <= w;
        i_cfg_addr <= a;
        i_cfg_be <= be;
        i_cfg_wdata <= wd;
        @(posedge i_clock);
        i_cfg_valid <= 1'b0;
        #1;
        chk({30'h0, o_cpl_valid, o_cpl_write}, {30'h0, 1'b1, w});
        chk(o_cpl_data, w ? 32'h0 : exp);
    endtask

    task end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung run
    initial begin
        #1000000;
        fails++;
        end_sim();
    end

    initial begin
        i_reset = 1'b1;
        i_sys_reset_n = 1'b0;
        i_cfg_valid = 1'b0;
        i_cfg_write = 1'b0;
        i_cfg_addr = 12'h000;
        i_cfg_be = 4'h0;
        i_cfg_wdata = 32'h0;
        inject = 1'b0;
        repeat (16) @(posedge i_clock);
        i_reset <= 1'b0;
        // system reset held 80 cycles in all, 5 past its minimum of 75 cycles
        repeat (64) @(posedge i_clock);
        i_sys_reset_n <= 1'b1;
        foreach (map[k]) acc(1'b0, map[k][43:32], 4'h0, 32'h0, map[k][31:0]);
        chk({24'h0, o_lane_used}, 32'h1);
        $display("test map done");
        for (int k = 0; k < 6; k++) begin
            acc(1'b1, 12'h010 + 12'(4 * k), 4'hf, 32'hffff_ffff, 32'h0);
            acc(1'b0, 12'h010 + 12'(4 * k), 4'h0, 32'h0, 32'hfff0_0000);
        end
        acc(1'b1, 12'h030, 4'hf, 32'hffff_ffff, 32'h0);
        acc(1'b0, 12'h030, 4'h0, 32'h0, 32'hfff0_0001);
        acc(1'b1, 12'h038, 4'hf, 32'hffff_ffff, 32'h0);
        acc(1'b0, 12'h038, 4'h0, 32'h0, 32'h0);
        acc(1'b1, 12'h3f0, 4'hf, 32'hffff_ffff, 32'h0);
        acc(1'b0, 12'h3f0, 4'h0, 32'h0, 32'h0);
        acc(1'b1, 12'h03c, 4'h1, 32'hffff_ffff, 32'h0);
        acc(1'b0, 12'h03c, 4'h0, 32'h0, 32'h0000_01ff);
        $display("test writes done");
        acc(1'b1, 12'h130, 4'hf, 32'h1, 32'h0);
        // three cycles with both receive legs equal
        @(posedge i_clock);
        inject <= 1'b1;
        repeat (3) @(posedge i_clock);
        inject <= 1'b0;
        @(negedge i_clock);
        v = rx_p[0];
        @(posedge i_clock);
        #1;
        chk({31'h0, o_tx_p[0]}, {31'h0, v});
        chk({31'h0, o_tx_n[0]}, {31'h0, ~o_tx_p[0]});
        acc(1'b0, 12'h134, 4'h0, 32'h0, 32'h0000_0103);
        acc(1'b0, 12'h138, 4'h0, 32'h0, 32'h3);
        $display("test loopback done");
        // system reset in mid-run clears writable state
        @(posedge i_clock);
        i_sys_reset_n <= 1'b0;
        repeat (76) @(posedge i_clock);
        i_sys_reset_n <= 1'b1;
        acc(1'b0, 12'h010, 4'h0, 32'h0, 32'h0);
        acc(1'b0, 12'h130, 4'h0, 32'h0, 32'h0);
        acc(1'b0, 12'h138, 4'h0, 32'h0, 32'h0);
        $display("test reset done");
        end_sim();
    end
endmodule
